// File: pkg/isrs_consts.svh
`ifndef ISRS_CONSTS_SVH
`define ISRS_CONSTS_SVH

// ****************************************
// set selectors on the command port
// ****************************************
`define ISRS_SET_DEV 3'h0
`define ISRS_SET_OPER 3'h1
`define ISRS_SET_CAL 3'h2
`define ISRS_SET_LLF 3'h3
`define ISRS_SET_MEAS 3'h4
`define ISRS_SET_SENSE 3'h5
`define ISRS_SET_TRIG 3'h6
`define ISRS_SET_COUNT 7

// ****************************************
// register selectors within a set
// ****************************************
`define ISRS_FLD_COND 3'h0
`define ISRS_FLD_EVENT 3'h1
`define ISRS_FLD_ENABLE 3'h2
`define ISRS_FLD_RISE 3'h3
`define ISRS_FLD_FALL 3'h4

// ****************************************
// reset values and write mask
// ****************************************
`define ISRS_WR_MASK 16'h7FFF
`define ISRS_RST_EVT 16'h0000
`define ISRS_RST_ENA_OPER 16'h0000
`define ISRS_RST_ENA_OTHER 16'h7FFF
`define ISRS_RST_RISE 16'h7FFF
`define ISRS_RST_FALL 16'h0000

// ****************************************
// implemented bits of each set
// ****************************************
`define ISRS_USED_DEV 16'h401E
`define ISRS_USED_OPER 16'h1C31
`define ISRS_USED_2CH 16'h0006
`define ISRS_USED_LLF 16'h007E

// ****************************************
// field positions
// ****************************************
`define ISRS_BIT_CH_A 1
`define ISRS_BIT_ERR_A 3
`define ISRS_BIT_KEY 14
`define ISRS_OP_CAL 0
`define ISRS_OP_MEAS 4
`define ISRS_OP_TRIG 5
`define ISRS_OP_SENSE 10
`define ISRS_OP_LLF 11
`define ISRS_OP_HLF 12

// width of the bundled pin vector
`define ISRS_PIN_W 40

`endif

// File: pkg/isrs_pkg.sv
`include "isrs_consts.svh"

package isrs_pkg;

  // ****************************************
  // types
  // ****************************************
  // which register set a command addresses
  typedef enum logic [2:0] {
    ISRS_DEV = `ISRS_SET_DEV,
    ISRS_OPER = `ISRS_SET_OPER,
    ISRS_CAL = `ISRS_SET_CAL,
    ISRS_LLF = `ISRS_SET_LLF,
    ISRS_MEAS = `ISRS_SET_MEAS,
    ISRS_SENSE = `ISRS_SET_SENSE,
    ISRS_TRIG = `ISRS_SET_TRIG
  } isrs_set_sel_type;

  // which register of a set a command addresses
  typedef enum logic [2:0] {
    ISRS_COND = `ISRS_FLD_COND,
    ISRS_EVENT = `ISRS_FLD_EVENT,
    ISRS_ENABLE = `ISRS_FLD_ENABLE,
    ISRS_RISE = `ISRS_FLD_RISE,
    ISRS_FALL = `ISRS_FLD_FALL
  } isrs_field_type;

  // state of one register set
  typedef struct packed {
    logic [15:0] cond;
    logic [15:0] evt;
    logic [15:0] ena;
    logic [15:0] rise;
    logic [15:0] fall;
    logic summary;
  } isrs_set_state_type;

  // state of the top block
  typedef struct packed {
    logic [`ISRS_PIN_W-1:0] prev;
    logic [1:0] cal;
    logic [5:0] llf;
    logic rsp_valid;
    logic [15:0] rsp_data;
  } isrs_top_state_type;

endpackage

// File: pkg/isrs_set_if.sv
`timescale 1ns/100ps
`default_nettype none

// link between the top and one register set
interface isrs_set_if;
  logic wr; // write strobe for this set
  logic rd_evt; // event read, clears the event register
  logic [2:0] field; // register selector
  logic [15:0] wdata; // write value
  logic [15:0] cond_in; // live condition bits
  logic [15:0] direct_in; // events that skip the filters
  logic [15:0] cond;
  logic [15:0] evt;
  logic [15:0] ena;
  logic [15:0] rise;
  logic [15:0] fall;
  logic summary; // or of enabled events

  modport owner (
    input wr, rd_evt, field, wdata, cond_in, direct_in,
    output cond, evt, ena, rise, fall, summary
  );
  modport ctrl (
    output wr, rd_evt, field, wdata, cond_in, direct_in,
    input cond, evt, ena, rise, fall, summary
  );
endinterface

`default_nettype wire

// File: rtl/isrs_sync.sv
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser for pin inputs
module isrs_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins in, synced levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta; // first stage, read only by the second
    logic [W-1:0] sync; // second stage
  } isrs_sync_state_type;

  isrs_sync_state_type regs;
  isrs_sync_state_type next_regs;

  // shift the pins through both stages
  always_comb begin
    next_regs.meta = d;
    next_regs.sync = regs.meta;
  end

  // register the state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regs <= '0;
    end else begin
      regs <= next_regs;
    end
  end

  assign q = regs.sync;
endmodule

`default_nettype wire

// File: rtl/isrs_set.sv
`timescale 1ns/100ps
`default_nettype none
`include "isrs_consts.svh"

// one status register set: condition, filters, event, enable
module isrs_set
  import isrs_pkg::*;
#(
  parameter logic [15:0] USED = `ISRS_USED_2CH,
  parameter logic [15:0] ENA_RST = `ISRS_RST_ENA_OTHER
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // access from the top
  isrs_set_if.owner bus
);
  isrs_set_state_type regs; // registered state
  isrs_set_state_type next_regs; // next state
  logic [15:0] new_evt; // events caught this cycle

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_regs = regs;
    // live view; bits outside the set read as zero
    next_regs.cond = bus.cond_in & USED; // see RL22
    // transitions gated by the filters; direct events skip them
    new_evt = ((next_regs.cond & ~regs.cond & regs.rise) // see RL3
      | (regs.cond & ~next_regs.cond & regs.fall) // see RL2
      | bus.direct_in) & USED; // see RL26
    // a new event beats the clear of a read in the same cycle
    next_regs.evt = (bus.rd_evt ? `ISRS_RST_EVT : regs.evt) | new_evt; // see RL4
    // filter and mask writes keep bits 0 to 14 only
    if (bus.wr) begin
      case (bus.field)
        `ISRS_FLD_ENABLE: next_regs.ena = bus.wdata & `ISRS_WR_MASK; // see RL23
        `ISRS_FLD_RISE: next_regs.rise = bus.wdata & `ISRS_WR_MASK; // see RL23
        `ISRS_FLD_FALL: next_regs.fall = bus.wdata & `ISRS_WR_MASK; // see RL23
        default: ; // condition and event cannot be written
      endcase
    end
    next_regs.summary = |(next_regs.evt & next_regs.ena); // see RL25
  end

  // register the state; filters and mask take their power-on values
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regs <= '{cond: 16'h0000, evt: `ISRS_RST_EVT, ena: ENA_RST,
                rise: `ISRS_RST_RISE, fall: `ISRS_RST_FALL, summary: 1'b0};
    end else begin
      regs <= next_regs;
    end
  end

  assign bus.cond = regs.cond;
  assign bus.evt = regs.evt;
  assign bus.ena = regs.ena;
  assign bus.rise = regs.rise;
  assign bus.fall = regs.fall;
  assign bus.summary = regs.summary;

  // ****************************************
  // checks
  // ****************************************
  a_evt_read_clear: assert property (@(posedge clk) disable iff (sys_rst) // see RL4
    bus.rd_evt && (new_evt == 16'h0000) |=> bus.evt == 16'h0000)
    else $error("event register not cleared by read");
  a_evt_latch_new: assert property (@(posedge clk) disable iff (sys_rst) // see RL3
    new_evt != 16'h0000 |=> (bus.evt & $past(new_evt)) == $past(new_evt))
    else $error("filtered transition not latched");
  a_filter_top_bit: assert property (@(posedge clk) disable iff (sys_rst) // see RL23
    bus.wr |=> !bus.ena[15] && !bus.rise[15] && !bus.fall[15])
    else $error("bit 15 of a filter or mask set");
  a_summary_or_out: assert property (@(posedge clk) disable iff (sys_rst) // see RL25
    bus.summary == |(bus.evt & bus.ena))
    else $error("set output differs from enabled events");
endmodule

`default_nettype wire

// File: rtl/isrs_top.sv
// Operation
// RL1 - sensor-attached condition bits follow sensor presence
// RL2 - enabled falling edge latches the event bit
// RL3 - enabled rising edge latches the event bit
// RL4 - event read returns contents, then clears
// RL5 - error bits: memory failed or dual inputs
// RL6 - key press latches device event bit 14
// RL7 - key press skips filters, condition reads zero
// RL8 - summary bits 0, 4, 5 from sets
// RL9 - summary bits 10, 11, 12 from sets
// RL10 - unused summary bits and bit 15 read zero
// RL11 - zeroing or calibration start sets calibrating bit
// RL12 - combined calibrate query also sets calibrating bit
// RL13 - calibrating bit clears when run completes
// RL14 - low-limit bits map channels and windows
// RL15 - failed low-limit test sets its bit
// RL16 - only an enabled passing test clears it
// RL17 - measuring bits high while channel acquires
// RL18 - measuring bit drops when measurement completes
// RL19 - sensor-read bits high during memory read
// RL20 - trigger-wait set uses bits 1 and 2
// RL21 - host selects register by set and selector
// RL22 - condition read returns live bits, unchanged
// RL23 - filter and mask writes force bit 15 low
// RL24 - parent summary bit is child output
// RL25 - set output is or of enabled events
// RL26 - all sets latch events through filters, but direct events skip them
`timescale 1ns/100ps
`default_nettype none
`include "isrs_consts.svh"

module isrs_top
  import isrs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host command port, same clock
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [2:0] cmd_set,
  input wire logic [2:0] cmd_field,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  // sensor pins, per channel, and the single key press pin
  input wire logic [1:0] sensor_present,
  input wire logic [1:0] sensor_mem_fail,
  input wire logic [1:0] sensor_dual_input,
  input wire logic key_press,
  // calibration activity, per channel
  input wire logic [1:0] single_zeroing_run,
  input wire logic [1:0] single_cal_run,
  input wire logic [1:0] cal_all_run,
  input wire logic [1:0] cal_run_done,
  // measurement activity, per channel
  input wire logic [1:0] acquiring,
  input wire logic [1:0] sensor_read_busy,
  input wire logic [1:0] trigger_wait,
  // limit tests: ch a, ch b, upper win, lower win, two lower meas
  input wire logic [5:0] meas_taken,
  input wire logic [5:0] low_limit_test_en,
  input wire logic [5:0] low_limit_test_fail,
  input wire logic high_limit_fail_summary,
  // set outputs
  output logic dev_summary,
  output logic oper_summary
);

  // ****************************************
  // helpers
  // ****************************************
  // implemented bits of each set
  function automatic logic [15:0] isrs_used(input int s);
    case (s)
      0: isrs_used = `ISRS_USED_DEV;
      1: isrs_used = `ISRS_USED_OPER;
      3: isrs_used = `ISRS_USED_LLF;
      default: isrs_used = `ISRS_USED_2CH;
    endcase
  endfunction

  // power-on enable mask; only the top operation set starts closed
  function automatic logic [15:0] isrs_ena_rst(input int s);
    if (s == 1) begin
      isrs_ena_rst = `ISRS_RST_ENA_OPER;
    end else begin
      isrs_ena_rst = `ISRS_RST_ENA_OTHER;
    end
  endfunction

  // pick one register of a set for a read
  function automatic logic [15:0] isrs_field_view(
    input logic [2:0] f,
    input logic [15:0] c,
    input logic [15:0] e,
    input logic [15:0] n,
    input logic [15:0] r,
    input logic [15:0] l
  );
    case (f)
      `ISRS_FLD_COND: isrs_field_view = c;
      `ISRS_FLD_EVENT: isrs_field_view = e;
      `ISRS_FLD_ENABLE: isrs_field_view = n;
      `ISRS_FLD_RISE: isrs_field_view = r;
      `ISRS_FLD_FALL: isrs_field_view = l;
      default: isrs_field_view = 16'h0000; // unknown selector reads zero
    endcase
  endfunction

  // ****************************************
  // pin synchronisation
  // ****************************************
  logic [`ISRS_PIN_W-1:0] pin_raw; // all asynchronous pins
  logic [`ISRS_PIN_W-1:0] pin_s; // synchronised copy

  assign pin_raw = {high_limit_fail_summary, low_limit_test_fail, low_limit_test_en,
                    meas_taken, trigger_wait, sensor_read_busy, acquiring,
                    cal_run_done, cal_all_run, single_cal_run, single_zeroing_run,
                    key_press, sensor_dual_input, sensor_mem_fail, sensor_present};

  // every pin passes two flops before any logic reads it
  isrs_sync #(
    .W(`ISRS_PIN_W)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(pin_raw),
    .q(pin_s)
  );

  // synced levels by name
  logic s_hlf;
  logic [5:0] s_fail;
  logic [5:0] s_en;
  logic [5:0] s_taken;
  logic [1:0] s_trig;
  logic [1:0] s_sread;
  logic [1:0] s_acq;
  logic [1:0] s_done;
  logic [1:0] s_calall;
  logic [1:0] s_cal;
  logic [1:0] s_zero;
  logic s_key;
  logic [1:0] s_dual;
  logic [1:0] s_memf;
  logic [1:0] s_pres;

  assign {s_hlf, s_fail, s_en, s_taken, s_trig, s_sread, s_acq, s_done, s_calall,
          s_cal, s_zero, s_key, s_dual, s_memf, s_pres} = pin_s;

  // ****************************************
  // state and set instances
  // ****************************************
  isrs_top_state_type regs; // registered state
  isrs_top_state_type next_regs; // next state
  logic [`ISRS_PIN_W-1:0] pin_rise; // one-cycle rising edges
  logic [1:0] cal_start; // any calibration run begins
  logic [5:0] llf_set; // failed test this cycle
  logic [5:0] llf_clr; // enabled passing test this cycle
  logic key_rise; // key press event
  logic [15:0] view [`ISRS_SET_COUNT]; // read mux per set

  isrs_set_if sif [`ISRS_SET_COUNT] ();

  // seven sets; command strobes decoded per set
  for (genvar g = 0; g < `ISRS_SET_COUNT; g++) begin : g_set
    isrs_set #(
      .USED(isrs_used(g)),
      .ENA_RST(isrs_ena_rst(g))
    ) u_set (
      .clk(clk),
      .sys_rst(sys_rst),
      .bus(sif[g])
    );
    // set path plus selector picks one register
    assign sif[g].wr = cmd_valid && cmd_write && (cmd_set == 3'(g)); // see RL21
    assign sif[g].rd_evt = cmd_valid && !cmd_write && (cmd_set == 3'(g))
      && (cmd_field == `ISRS_FLD_EVENT); // see RL4
    assign sif[g].field = cmd_field;
    assign sif[g].wdata = cmd_wdata;
    assign view[g] = isrs_field_view(cmd_field, sif[g].cond, sif[g].evt, sif[g].ena,
                                     sif[g].rise, sif[g].fall);
  end

  // ****************************************
  // condition vectors
  // ****************************************
  // device set: presence, sensor errors, key press as a direct event
  assign sif[0].cond_in = {11'h000, s_memf | s_dual, s_pres, 1'b0}; // see RL1
  // error bits also cover a sensor on both inputs  // see RL5
  assign sif[0].direct_in = {1'b0, key_rise, 14'h0000}; // see RL6
  // key press has no live view, so no transitions  // see RL7

  // operation summary: child outputs on their own bits
  assign sif[1].cond_in = {3'h0, s_hlf, sif[3].summary, sif[5].summary, 4'h0,
                           sif[6].summary, sif[4].summary, 3'h0, sif[2].summary}; // see RL24
  // bits 0, 4, 5 and 10 to 12 are the summaries  // see RL8
  // others stay zero, bit 15 too  // see RL10
  // upper-limit set lives elsewhere, its summary arrives on a pin  // see RL9
  assign sif[1].direct_in = 16'h0000;
  assign sif[2].cond_in = {13'h0000, regs.cal, 1'b0}; // see RL11
  assign sif[2].direct_in = 16'h0000;
  assign sif[3].cond_in = {9'h000, regs.llf, 1'b0}; // see RL14
  assign sif[3].direct_in = 16'h0000;
  // measuring bits are the live acquire level  // see RL18
  assign sif[4].cond_in = {13'h0000, s_acq, 1'b0}; // see RL17
  assign sif[4].direct_in = 16'h0000;
  assign sif[5].cond_in = {13'h0000, s_sread, 1'b0}; // see RL19
  assign sif[5].direct_in = 16'h0000;
  assign sif[6].cond_in = {13'h0000, s_trig, 1'b0}; // see RL20
  assign sif[6].direct_in = 16'h0000;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_regs = regs;
    next_regs.prev = pin_s;
    pin_rise = pin_s & ~regs.prev;
    key_rise = s_key && !regs.prev[6];
    // start of zeroing, calibration or the combined query
    cal_start = (s_zero & ~regs.prev[8:7]) | (s_cal & ~regs.prev[10:9])
      | (s_calall & ~regs.prev[12:11]); // see RL12
    // a start wins over a completion landing in the same cycle
    next_regs.cal = (regs.cal & ~(s_done & ~regs.prev[14:13])) | cal_start; // see RL13
    // limit tests resolve only when a measurement is taken
    llf_set = (s_taken & ~regs.prev[26:21]) & s_en & s_fail; // see RL15
    llf_clr = (s_taken & ~regs.prev[26:21]) & s_en & ~s_fail; // see RL16
    next_regs.llf = (regs.llf & ~llf_clr) | llf_set;
    // one-cycle answer to every read
    next_regs.rsp_valid = cmd_valid && !cmd_write;
    if (cmd_valid && !cmd_write) begin
      if (cmd_set < 3'(`ISRS_SET_COUNT)) begin
        next_regs.rsp_data = view[cmd_set]; // see RL22
      end else begin
        next_regs.rsp_data = 16'h0000; // unmapped set reads zero
      end
    end
  end

  // register the state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regs <= '0;
    end else begin
      regs <= next_regs;
    end
  end

  // outputs straight from flops
  assign rsp_valid = regs.rsp_valid;
  assign rsp_data = regs.rsp_data;
  assign dev_summary = sif[0].summary;
  assign oper_summary = sif[1].summary;

  // ****************************************
  // checks
  // ****************************************
  a_sensor_cond_live: assert property (@(posedge clk) disable iff (sys_rst) // see RL1
    sensor_present[0] [*4] |=> sif[0].cond[1])
    else $error("channel a presence not shown");
  a_sensor_err_bit: assert property (@(posedge clk) disable iff (sys_rst) // see RL5
    sensor_mem_fail[1] [*4] |=> sif[0].cond[4])
    else $error("channel b sensor error not shown");
  a_key_cond_zero: assert property (@(posedge clk) disable iff (sys_rst) // see RL7
    sif[0].cond[14] == 1'b0)
    else $error("key press condition not zero");
  a_key_evt_latch: assert property (@(posedge clk) disable iff (sys_rst) // see RL6
    key_rise |-> ##1 sif[0].evt[14])
    else $error("key press event lost");
  a_oper_unused_zero: assert property (@(posedge clk) disable iff (sys_rst) // see RL10
    (sif[1].cond & ~`ISRS_USED_OPER) == 16'h0000)
    else $error("unused summary bit set");
  a_oper_cal_sum: assert property (@(posedge clk) disable iff (sys_rst) // see RL24
    sif[1].cond[0] == $past(sif[2].summary))
    else $error("calibrating summary not forwarded");
  a_oper_meas_sum: assert property (@(posedge clk) disable iff (sys_rst) // see RL8
    sif[1].cond[4] == $past(sif[4].summary))
    else $error("measuring summary not forwarded");
  a_cal_start_set: assert property (@(posedge clk) disable iff (sys_rst) // see RL11
    cal_start[0] |=> regs.cal[0] ##1 sif[2].cond[1])
    else $error("calibrating bit not set at start");
  a_cal_done_clear: assert property (@(posedge clk) disable iff (sys_rst) // see RL13
    pin_rise[13] && !cal_start[0] |=> !regs.cal[0])
    else $error("calibrating bit not cleared at end");
  a_llf_fail_set: assert property (@(posedge clk) disable iff (sys_rst) // see RL15
    llf_set != 6'h00 |=> (regs.llf & $past(llf_set)) == $past(llf_set))
    else $error("limit fail bit not set");
  a_llf_hold_clear: assert property (@(posedge clk) disable iff (sys_rst) // see RL16
    regs.llf[0] && !llf_clr[0] |=> regs.llf[0])
    else $error("limit fail bit dropped without a pass");
  a_read_answer: assert property (@(posedge clk) disable iff (sys_rst) // see RL22
    cmd_valid && !cmd_write && cmd_set == `ISRS_SET_DEV && cmd_field == `ISRS_FLD_COND
    |=> rsp_valid && rsp_data == $past(sif[0].cond))
    else $error("condition read answer wrong");

  c_event_read: cover property (@(posedge clk) disable iff (sys_rst)
    rsp_valid && rsp_data != 16'h0000);
  c_cal_run: cover property (@(posedge clk) disable iff (sys_rst)
    regs.cal[1] ##[1:50] !regs.cal[1]);
  c_key_event: cover property (@(posedge clk) disable iff (sys_rst)
    sif[0].evt[14]);
  c_oper_summary: cover property (@(posedge clk) disable iff (sys_rst)
    oper_summary);

endmodule

`default_nettype wire

// File: testbench/isrs_host.sv
`timescale 1ns/100ps
`default_nettype none

// ******
// host model: one command at a time on the port
// ******
module isrs_host (
  // clock
  input wire logic clk,
  // command port
  output logic cmd_valid,
  output logic cmd_write,
  output logic [2:0] cmd_set,
  output logic [2:0] cmd_field,
  output logic [15:0] cmd_wdata,
  // read answer
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data
);
  // idle port from time zero so nothing is taken during reset
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_set = 3'h0;
    cmd_field = 3'h0;
    cmd_wdata = 16'h0000;
  end

  // a command names the set and then its selector
  task automatic issue(input logic w, input logic [2:0] s, input logic [2:0] f,
                       input logic [15:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_set <= s;
    cmd_field <= f;
    cmd_wdata <= d;
    // one-cycle strobe: dropped at the edge that takes it
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask

  // read: the answer is waited for over a few cycles only
  task automatic rd(input logic [2:0] s, input logic [2:0] f,
                    output logic [15:0] d, output logic ok);
    issue(1'b0, s, f, 16'h0000);
    ok = 1'b0;
    d = 16'h0000;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (rsp_valid === 1'b1) begin
        ok = 1'b1;
        d = rsp_data;
      end else begin
        @(posedge clk);
      end
    end
  endtask
endmodule

`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  // ******
  // signals
  // ******
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid, cmd_write, rsp_valid, dev_summary, oper_summary;
  logic [2:0] cmd_set, cmd_field;
  logic [15:0] cmd_wdata, rsp_data;
  logic [1:0] present = 2'h0, mem_fail = 2'h0, dual = 2'h0, zero_run = 2'h0;
  logic [1:0] cal_run = 2'h0, cal_all = 2'h0, done = 2'h0, acq = 2'h0;
  logic [1:0] sread = 2'h0, twait = 2'h0;
  logic [5:0] taken = 6'h00, ll_en = 6'h00, ll_fail = 6'h00;
  logic key = 1'b0, hlf = 1'b0;
  int n_fail = 0;
  int n_checks = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  isrs_top DUT (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_set(cmd_set), .cmd_field(cmd_field),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .sensor_present(present), .sensor_mem_fail(mem_fail),
    .sensor_dual_input(dual), .key_press(key), .single_zeroing_run(zero_run),
    .single_cal_run(cal_run), .cal_all_run(cal_all), .cal_run_done(done),
    .acquiring(acq), .sensor_read_busy(sread), .trigger_wait(twait),
    .meas_taken(taken), .low_limit_test_en(ll_en), .low_limit_test_fail(ll_fail),
    .high_limit_fail_summary(hlf), .dev_summary(dev_summary),
    .oper_summary(oper_summary));

  isrs_host HOST (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_set(cmd_set), .cmd_field(cmd_field), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));

  // ******
  // helpers
  // ******
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // read and compare; a missing answer ends the run
  task automatic rdc(input logic [2:0] s, input logic [2:0] f, input logic [15:0] exp,
                     input string nm);
    logic [15:0] d;
    logic ok;
    HOST.rd(s, f, d, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %s expected answer seen none", nm);
      end_of_test();
    end else begin
      check(nm, exp, d);
    end
  endtask

  // pins pass a two-flop sync, so give them time to land
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  // ******
  // main sequence
  // ******
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(3'h0, 3'h2, 16'h7FFF, "dev enable");
    rdc(3'h0, 3'h3, 16'h7FFF, "dev rising");
    rdc(3'h0, 3'h4, 16'h0000, "dev falling");
    rdc(3'h1, 3'h2, 16'h0000, "oper enable");
    $display("done: reset values");
    HOST.issue(1'b1, 3'h0, 3'h2, 16'hFFFF);
    rdc(3'h0, 3'h2, 16'h7FFF, "dev enable bit15");
    HOST.issue(1'b1, 3'h0, 3'h0, 16'h1234);
    rdc(3'h0, 3'h0, 16'h0000, "cond not writable");
    rdc(3'h7, 3'h1, 16'h0000, "unmapped set");
    rdc(3'h0, 3'h5, 16'h0000, "unknown selector");
    $display("done: writes");
    @(posedge clk);
    present <= 2'h1;
    settle();
    rdc(3'h0, 3'h0, 16'h0002, "attach cond");
    rdc(3'h0, 3'h0, 16'h0002, "cond reread");
    rdc(3'h0, 3'h1, 16'h0002, "attach event");
    rdc(3'h0, 3'h1, 16'h0000, "event cleared");
    HOST.issue(1'b1, 3'h0, 3'h4, 16'h0002);
    @(posedge clk);
    present <= 2'h0;
    settle();
    rdc(3'h0, 3'h0, 16'h0000, "detach cond");
    rdc(3'h0, 3'h1, 16'h0002, "detach event");
    @(posedge clk);
    key <= 1'b1;
    settle();
    rdc(3'h0, 3'h1, 16'h4000, "key event");
    rdc(3'h0, 3'h0, 16'h0000, "key cond");
    @(posedge clk);
    key <= 1'b0;
    mem_fail <= 2'h2;
    dual <= 2'h1;
    settle();
    rdc(3'h0, 3'h0, 16'h0018, "error cond");
    check("dev summary", 16'h0001, {15'h0000, dev_summary});
    $display("done: device set");
    @(posedge clk);
    acq <= 2'h2;
    sread <= 2'h2;
    twait <= 2'h2;
    hlf <= 1'b1;
    settle();
    for (int s = 4; s < 7; s++) rdc(3'(s), 3'h0, 16'h0004, "activity cond");
    rdc(3'h1, 3'h0, 16'h1430, "oper cond");
    @(posedge clk);
    acq <= 2'h0;
    sread <= 2'h0;
    twait <= 2'h0;
    settle();
    for (int s = 4; s < 7; s++) rdc(3'(s), 3'h0, 16'h0000, "activity done");
    $display("done: activity sets");
    @(posedge clk);
    zero_run <= 2'h1;
    cal_all <= 2'h2;
    settle();
    rdc(3'h2, 3'h0, 16'h0006, "cal start");
    @(posedge clk);
    done <= 2'h3;
    settle();
    rdc(3'h2, 3'h0, 16'h0000, "cal end");
    $display("done: calibrating set");
    @(posedge clk);
    ll_en <= 6'h21;
    ll_fail <= 6'h21;
    taken <= 6'h21;
    settle();
    rdc(3'h3, 3'h0, 16'h0042, "limit fail");
    // passing levels without a new measurement must not clear
    @(posedge clk);
    ll_fail <= 6'h00;
    settle();
    rdc(3'h3, 3'h0, 16'h0042, "no new measurement");
    @(posedge clk);
    taken <= 6'h00;
    ll_en <= 6'h01;
    ll_fail <= 6'h00;
    settle();
    @(posedge clk);
    taken <= 6'h21;
    settle();
    rdc(3'h3, 3'h0, 16'h0040, "limit pass");
    rdc(3'h1, 3'h0, 16'h1C31, "oper final");
    check("oper summary", 16'h0000, {15'h0000, oper_summary});
    HOST.issue(1'b1, 3'h1, 3'h2, 16'h0800);
    rdc(3'h1, 3'h2, 16'h0800, "oper enable set");
    check("oper summary on", 16'h0001, {15'h0000, oper_summary});
    $display("done: limit set");
    end_of_test();
  end
endmodule

`default_nettype wire
